// ### rtl/tes_top.sv
// trigger conditioning, exposure sequencing and auto exposure loop
// Functional notes
// [R1] 12-bit brightness target; 8-bit level times 16
// [R2] meter average or peak, whole frame or window
// [R3] both loops on: exposure first, gain only at exposure max; code lowers gain first when darkening
// [R4] clamp flags the limit and holds until luminance changes
// [R5] four convergence rates set the step size
// [R6] meter all pixels, or window only when slaved
// [R7] luminance, exposure and gain are read back
// [R8] hardware trigger from input one or two on chosen edge
// [R9] glitch filter drops short pin pulses
// [R10] holdoff period ignores triggers after each one
// [R11] each output maps one of fifteen signals with chosen polarity
// [R12] standard: full exposure then readout; source spaces triggers
// [R13] standard: set frame count per trigger, default 1
// [R14] timer exposure starts at trigger, length manual or auto
// [R15] pulse width exposure lasts while trigger is active
// [R16] fast timer pulses 10 us wide, period over readout
// [R17] fast timer exposure ends with readout; next readout on trigger
// [R18] fast mode drops triggers in the running period
// [R19] fast timer exposure up to 16 seconds
// [R20] fast pulse width exposure starts on trigger during readout
// [R21] five sources: two inputs, pulse gen, software, cc1
// [R22] one short pulse per software command
// [R23] overlap ignore drops busy triggers; accept restarts the cycle
// [R24] pulse width: low level on falling edge, high on rising
// [R25] free run ignores triggers, reads out continuously
// [R26] glitch filter first, holdoff second, then sequencer
`timescale 1ns/1ps
`include "tes_regs.svh"

module tes_top #(
  parameter int EXP_W  = 30,
  parameter int GAIN_W = 12,
  parameter int LUM_W  = 12,
  parameter int CNT_W  = 24
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  input  wire logic              i_triggered,
  input  wire logic              i_fast_mode,
  input  wire logic              i_pulse_width,
  input  wire logic              i_edge_falling,
  input  wire logic              i_overlap_accept,
  input  wire logic [2:0]        i_trig_src,
  input  wire logic [CNT_W-1:0]  i_frames_per_trig,
  input  wire logic [CNT_W-1:0]  i_glitch_min,
  input  wire logic [CNT_W-1:0]  i_trigger_holdoff,
  input  wire logic [EXP_W-1:0]  i_exp_time,
  input  wire logic [CNT_W-1:0]  i_readout_time,
  input  wire logic              i_trigger_input_one,
  input  wire logic              i_trigger_input_two,
  input  wire logic              i_cc1,
  input  wire logic              i_pulse_gen,
  input  wire logic              i_sw_trig,
  input  wire logic              i_ae_en,
  input  wire logic              i_ag_en,
  input  wire logic [LUM_W-1:0]  i_lum_target,
  input  wire logic              i_use_peak,
  input  wire logic              i_slaved_window_metering,
  input  wire logic [1:0]        i_ae_speed,
  input  wire logic [EXP_W-1:0]  i_exp_min,
  input  wire logic [EXP_W-1:0]  i_exp_max,
  input  wire logic [GAIN_W-1:0] i_gain_min,
  input  wire logic [GAIN_W-1:0] i_gain_max,
  input  wire logic              i_pix_valid,
  input  wire logic [LUM_W-1:0]  i_pix_data,
  input  wire logic              i_pix_in_window,
  input  wire logic              i_frame_end,
  input  wire logic [3:0]        i_out1_sel,
  input  wire logic              i_out1_low,
  input  wire logic [3:0]        i_out2_sel,
  input  wire logic              i_out2_low,
  output logic                   o_out1,
  output logic                   o_out2,
  output logic                   o_exposing,
  output logic                   o_readout,
  output logic                   o_frame_start,
  output logic                   o_trig_accepted,
  output logic [LUM_W-1:0]       o_lum,
  output logic [EXP_W-1:0]       o_exp_cur,
  output logic [GAIN_W-1:0]      o_gain_cur,
  output logic                   o_exp_limit,
  output logic                   o_gain_limit
);

  logic [2:0]         sync1_q;
  logic [2:0]         sync2_q;
  logic               sw_pulse_q;
  logic               raw_lvl;
  logic               act_lvl;
  logic               pin_src;
  logic [CNT_W-1:0]   glt_cnt_q;
  logic               filt_q;
  logic               filt_prev_q;
  logic [CNT_W-1:0]   hold_cnt_q;
  logic               trig_ok;
  tes_pkg::tes_state_e state_q;
  logic [CNT_W-1:0]   rd_cnt_q;
  logic [EXP_W-1:0]   exp_cnt_q;
  logic [CNT_W-1:0]   frames_left_q;
  logic               exp_prev_q;
  logic               rd_busy;
  logic               standard;
  logic [EXP_W-1:0]   exp_len;
  logic [CNT_W-1:0]   fpt;
  logic [35:0]        sum_q;
  logic [CNT_W-1:0]   pix_cnt_q;
  logic [LUM_W-1:0]   peak_q;
  logic               meas_new_q;
  logic [LUM_W-1:0]   prev_lum_q;
  logic               metered;
  logic               up;
  logic               dn;
  logic               same;
  logic               exp_path;
  logic [LUM_W-1:0]   err;
  logic [LUM_W-1:0]   step;
  logic [2:0]         shift;
  logic [EXP_W:0]     exp_up;
  logic [EXP_W-1:0]   exp_stp;
  logic [GAIN_W:0]    gain_up;
  logic [GAIN_W-1:0]  gain_stp;
  logic [15:0]        map_sig;

  // two-flop synchronisers for the pins
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (i_ce) begin
      sync1_q <= {i_cc1, i_trigger_input_two, i_trigger_input_one};
      sync2_q <= sync1_q;
    end
  end

  // [R22] one pulse per command
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_pulse_q <= 1'b0;
    end else if (i_ce) begin
      sw_pulse_q <= i_sw_trig;
    end
  end

  // [R21] source selection
  always_comb begin
    raw_lvl = 1'b0;
    pin_src = 1'b0;
    case (i_trig_src)
      tes_pkg::TES_SRC_IN1: begin
        raw_lvl = sync2_q[0];
        pin_src = 1'b1;
      end
      tes_pkg::TES_SRC_IN2: begin
        raw_lvl = sync2_q[1];
        pin_src = 1'b1;
      end
      tes_pkg::TES_SRC_PGEN: raw_lvl = i_pulse_gen;
      tes_pkg::TES_SRC_SW:   raw_lvl = sw_pulse_q;
      tes_pkg::TES_SRC_CC1:  raw_lvl = sync2_q[2];
      default:               raw_lvl = 1'b0;
    endcase
  end

  // [R8] active level follows the chosen edge
  assign act_lvl = raw_lvl ^ i_edge_falling;

  // [R9] glitch filter on pin sources
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      glt_cnt_q <= '0;
      filt_q    <= 1'b0;
    end else if (i_ce) begin
      if (!act_lvl) begin
        glt_cnt_q <= '0;
        filt_q    <= 1'b0;
      end else if (!pin_src || glt_cnt_q >= i_glitch_min) begin
        filt_q <= 1'b1;
      end else begin
        glt_cnt_q <= glt_cnt_q + 1'b1;
      end
    end
  end

  // [R26] holdoff sees only the filtered edge
  // [R25] no trigger passes in free-running mode
  assign trig_ok = filt_q && !filt_prev_q && hold_cnt_q == '0
                   && i_triggered;

  // [R10] holdoff window after each trigger
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      filt_prev_q <= 1'b0;
      hold_cnt_q  <= '0;
    end else if (i_ce) begin
      filt_prev_q <= filt_q;
      if (trig_ok) begin
        hold_cnt_q <= i_trigger_holdoff;
      end else if (hold_cnt_q != '0) begin
        hold_cnt_q <= hold_cnt_q - 1'b1;
      end
    end
  end

  // [R14] manual or automatic exposure length
  assign exp_len  = i_ae_en ? o_exp_cur : i_exp_time;
  assign rd_busy  = rd_cnt_q != '0;
  assign standard = i_triggered && !i_fast_mode;
  // [R13] a zero count behaves as one frame
  assign fpt = (i_frames_per_trig == '0) ? `TES_FRAMES_ONE
                                         : i_frames_per_trig;

  // exposure and readout sequencer
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q         <= tes_pkg::TES_ST_IDLE;
      rd_cnt_q        <= '0;
      exp_cnt_q       <= '0;
      frames_left_q   <= '0;
      o_exposing      <= 1'b0;
      o_frame_start   <= 1'b0;
      o_trig_accepted <= 1'b0;
    end else if (i_ce) begin
      o_frame_start   <= 1'b0;
      o_trig_accepted <= 1'b0;
      if (rd_busy) begin
        rd_cnt_q <= rd_cnt_q - 1'b1;
      end
      if (standard) begin
        case (state_q)
          tes_pkg::TES_ST_IDLE: begin
            if (trig_ok) begin
              state_q         <= tes_pkg::TES_ST_EXPOSE;
              exp_cnt_q       <= exp_len;
              frames_left_q   <= fpt;
              o_exposing      <= 1'b1;
              o_trig_accepted <= 1'b1;
            end
          end
          default: begin
            // [R23] overlap policy
            if (trig_ok && i_overlap_accept) begin
              state_q         <= tes_pkg::TES_ST_EXPOSE;
              exp_cnt_q       <= exp_len;
              frames_left_q   <= fpt;
              rd_cnt_q        <= '0;
              o_exposing      <= 1'b1;
              o_trig_accepted <= 1'b1;
            end else if (state_q == tes_pkg::TES_ST_EXPOSE) begin
              // [R15] [R24] pulse width end
              // [R12] readout after exposure
              if (i_pulse_width ? !filt_q : exp_cnt_q <= 1) begin
                state_q       <= tes_pkg::TES_ST_READ;
                rd_cnt_q      <= i_readout_time;
                o_exposing    <= 1'b0;
                o_frame_start <= 1'b1;
              end else begin
                exp_cnt_q <= exp_cnt_q - 1'b1;
              end
            end else if (rd_cnt_q <= 1) begin
              // [R13] next frame
              if (frames_left_q > 1 && !i_pulse_width) begin
                state_q       <= tes_pkg::TES_ST_EXPOSE;
                frames_left_q <= frames_left_q - 1'b1;
                exp_cnt_q     <= exp_len;
                o_exposing    <= 1'b1;
              end else begin
                state_q <= tes_pkg::TES_ST_IDLE;
              end
            end
          end
        endcase
      end else begin
        state_q <= tes_pkg::TES_ST_IDLE;
        if (!i_triggered) begin
          // [R25] continuous readout
          if (rd_cnt_q <= 1) begin
            rd_cnt_q      <= i_readout_time;
            o_frame_start <= 1'b1;
          end
          o_exposing <= rd_busy && EXP_W'(rd_cnt_q) <= exp_len;
        end else if (i_pulse_width) begin
          // [R20] [R18] pulse width exposure
          if (trig_ok && !o_exposing) begin
            o_exposing      <= 1'b1;
            o_trig_accepted <= 1'b1;
          end else if (o_exposing && !filt_q) begin
            o_exposing    <= 1'b0;
            rd_cnt_q      <= i_readout_time;
            o_frame_start <= 1'b1;
          end
        end else begin
          // [R18] drop busy triggers
          if (trig_ok && !rd_busy) begin
            rd_cnt_q        <= i_readout_time;
            o_frame_start   <= 1'b1;
            o_trig_accepted <= 1'b1;
          end
          // [R17] [R19] exposure ends with readout
          o_exposing <= rd_busy && EXP_W'(rd_cnt_q) <= exp_len;
        end
      end
    end
  end

  // [R6] window metering
  assign metered = i_pix_valid &&
                   (!i_slaved_window_metering || i_pix_in_window);

  // [R2] average or peak luminance per frame
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sum_q      <= '0;
      pix_cnt_q  <= '0;
      peak_q     <= '0;
      o_lum      <= '0;
      meas_new_q <= 1'b0;
    end else if (i_ce) begin
      meas_new_q <= i_frame_end;
      if (i_frame_end) begin
        sum_q     <= '0;
        pix_cnt_q <= '0;
        peak_q    <= '0;
        if (i_use_peak) begin
          o_lum <= peak_q;
        end else if (pix_cnt_q != '0) begin
          o_lum <= LUM_W'(sum_q / pix_cnt_q);
        end
      end else if (metered) begin
        sum_q     <= sum_q + 36'(i_pix_data);
        pix_cnt_q <= pix_cnt_q + 1'b1;
        if (i_pix_data > peak_q) begin
          peak_q <= i_pix_data;
        end
      end
    end
  end

  // [R1] twelve-bit target compared directly
  assign up   = o_lum < i_lum_target;
  assign dn   = o_lum > i_lum_target;
  assign err  = up ? i_lum_target - o_lum : o_lum - i_lum_target;
  // [R5] four step sizes
  assign shift = `TES_SPEED_BASE + {i_ae_speed, 1'b0};
  assign step  = ((err >> shift) == '0) ? LUM_W'(1) : err >> shift;
  assign same  = o_lum == prev_lum_q;
  // [R3] outside pulse width mode, brightening: exposure first, gain only at exposure max; darkening: gain first, exposure only at gain min
  assign exp_path = i_ae_en && !i_pulse_width &&
                    (!i_ag_en || (up ? o_exp_cur < i_exp_max
                                     : o_gain_cur <= i_gain_min));
  assign exp_up   = {1'b0, o_exp_cur} + (EXP_W+1)'(step);
  assign exp_stp  = EXP_W'(step);
  assign gain_up  = {1'b0, o_gain_cur} + (GAIN_W+1)'(step);
  assign gain_stp = GAIN_W'(step);

  // [R7] loop readback
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_exp_cur    <= `TES_EXP_RST;
      o_gain_cur   <= `TES_GAIN_RST;
      o_exp_limit  <= 1'b0;
      o_gain_limit <= 1'b0;
      prev_lum_q   <= '0;
    end else if (i_ce && meas_new_q) begin
      prev_lum_q <= o_lum;
      // [R4] flags clear when the light level moves
      if (!same) begin
        o_exp_limit  <= 1'b0;
        o_gain_limit <= 1'b0;
      end
      if (exp_path && !(o_exp_limit && same)) begin
        if (up) begin
          if (exp_up >= {1'b0, i_exp_max}) begin
            o_exp_cur   <= i_exp_max;
            o_exp_limit <= 1'b1;
          end else begin
            o_exp_cur <= EXP_W'(exp_up);
          end
        end else if (dn) begin
          if (o_exp_cur <= i_exp_min + exp_stp) begin
            o_exp_cur   <= i_exp_min;
            o_exp_limit <= 1'b1;
          end else begin
            o_exp_cur <= o_exp_cur - exp_stp;
          end
        end
      end else if (i_ag_en && !exp_path &&
                   !(o_gain_limit && same)) begin
        if (up) begin
          if (gain_up >= {1'b0, i_gain_max}) begin
            o_gain_cur   <= i_gain_max;
            o_gain_limit <= 1'b1;
          end else begin
            o_gain_cur <= GAIN_W'(gain_up);
          end
        end else if (dn) begin
          if (o_gain_cur <= i_gain_min + gain_stp) begin
            o_gain_cur   <= i_gain_min;
            o_gain_limit <= 1'b1;
          end else begin
            o_gain_cur <= o_gain_cur - gain_stp;
          end
        end
      end
    end
  end

  // mapper sources
  always_comb begin
    map_sig                  = '0;
    map_sig[`TES_MAP_EXPO]   = o_exposing;
    map_sig[`TES_MAP_READ]   = rd_busy;
    map_sig[`TES_MAP_FSTART] = o_frame_start;
    map_sig[`TES_MAP_TACC]   = o_trig_accepted;
    map_sig[`TES_MAP_TLEVEL] = filt_q;
    map_sig[`TES_MAP_IN1]    = sync2_q[0];
    map_sig[`TES_MAP_IN2]    = sync2_q[1];
    map_sig[`TES_MAP_CC1]    = sync2_q[2];
    map_sig[`TES_MAP_PGEN]   = i_pulse_gen;
    map_sig[`TES_MAP_SWTRIG] = sw_pulse_q;
    map_sig[`TES_MAP_ELIM]   = o_exp_limit;
    map_sig[`TES_MAP_GLIM]   = o_gain_limit;
    map_sig[`TES_MAP_HOLD]   = hold_cnt_q != '0;
    map_sig[`TES_MAP_ESTART] = o_exposing && !exp_prev_q;
    map_sig[`TES_MAP_EEND]   = !o_exposing && exp_prev_q;
  end

  // [R11] mapped outputs with polarity
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      exp_prev_q <= 1'b0;
      o_readout  <= 1'b0;
      o_out1     <= 1'b0;
      o_out2     <= 1'b0;
    end else if (i_ce) begin
      exp_prev_q <= o_exposing;
      o_readout  <= rd_busy;
      o_out1     <= map_sig[i_out1_sel] ^ i_out1_low;
      o_out2     <= map_sig[i_out2_sel] ^ i_out2_low;
    end
  end

endmodule

// ### rtl/tes_regs.svh
// constants of the trigger and exposure sequencer
`ifndef TES_REGS_SVH
`define TES_REGS_SVH

// reset values of the exposure and gain loop, and the one-frame count
`define TES_EXP_RST     30'h0000_1388
`define TES_GAIN_RST    12'h000
`define TES_FRAMES_ONE  24'h00_0001

// convergence step shift for the fastest rate
`define TES_SPEED_BASE  3'h0

// positions of the signals offered to the output mapper
`define TES_MAP_NONE    0
`define TES_MAP_EXPO    1
`define TES_MAP_READ    2
`define TES_MAP_FSTART  3
`define TES_MAP_TACC    4
`define TES_MAP_TLEVEL  5
`define TES_MAP_IN1     6
`define TES_MAP_IN2     7
`define TES_MAP_CC1     8
`define TES_MAP_PGEN    9
`define TES_MAP_SWTRIG  10
`define TES_MAP_ELIM    11
`define TES_MAP_GLIM    12
`define TES_MAP_HOLD    13
`define TES_MAP_ESTART  14
`define TES_MAP_EEND    15

`endif

// ### rtl/tes_pkg.sv
// types of the trigger and exposure sequencer
package tes_pkg;

  typedef enum logic [2:0] {
    TES_SRC_IN1  = 3'h0,
    TES_SRC_IN2  = 3'h1,
    TES_SRC_PGEN = 3'h2,
    TES_SRC_SW   = 3'h3,
    TES_SRC_CC1  = 3'h4
  } tes_src_e;

  typedef enum logic [2:0] {
    TES_ST_IDLE   = 3'b001,
    TES_ST_EXPOSE = 3'b010,
    TES_ST_READ   = 3'b100
  } tes_state_e;

endpackage

// ### testbench/tes_trig_model.sv
// external trigger source on the trigger pins
`timescale 1ns/1ps

module tes_trig_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_fire,
  input  wire logic [7:0] i_width,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_low,
  output logic            o_in1,
  output logic            o_in2,
  output logic            o_cc1
);
  logic [7:0] left_q;
  logic       act;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      left_q <= 8'h00;
    end else if (i_fire && left_q == 8'h00) begin
      left_q <= i_width;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  assign act = left_q != 8'h00;
  assign o_in1 = (act && i_sel == 3'h0) ^ i_low;
  assign o_in2 = (act && i_sel == 3'h1) ^ i_low;
  assign o_cc1 = (act && i_sel == 3'h4) ^ i_low;
endmodule

// ### testbench/tes_top_assertions.sv
// port checks of the sequencer
`timescale 1ns/1ps

module tes_top_chk #(
  parameter int EXP_W = 30,
  parameter int CNT_W = 24
) (
  input wire logic             i_sys_clk,
  input wire logic             i_nrst,
  input wire logic             i_triggered,
  input wire logic             i_fast_mode,
  input wire logic             i_pulse_width,
  input wire logic [2:0]       i_trig_src,
  input wire logic [CNT_W-1:0] i_trigger_holdoff,
  input wire logic [EXP_W-1:0] i_exp_time,
  input wire logic [CNT_W-1:0] i_readout_time,
  input wire logic             i_sw_trig,
  input wire logic             i_ae_en,
  input wire logic [EXP_W-1:0] i_exp_min,
  input wire logic [EXP_W-1:0] i_exp_max,
  input wire logic [3:0]       i_out1_sel,
  input wire logic             i_out1_low,
  input wire logic             o_out1,
  input wire logic             o_exposing,
  input wire logic             o_readout,
  input wire logic             o_frame_start,
  input wire logic             o_trig_accepted,
  input wire logic [EXP_W-1:0] o_exp_cur,
  input wire logic             o_exp_limit
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  logic [EXP_W-1:0] len_q;
  logic [CNT_W-1:0] since_q;

  // exposure length so far; cycles since the last accept
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      len_q   <= '0;
      since_q <= '0;
    end else begin
      len_q   <= o_exposing ? len_q + 1'b1 : '0;
      since_q <= o_trig_accepted ? '0 : since_q + CNT_W'(~&since_q);
    end
  end

  property p_exp_len;
    $fell(o_exposing) && i_triggered && !i_fast_mode && !i_pulse_width
      && !i_ae_en && i_exp_time > 1 |-> len_q == i_exp_time;
  endproperty
  a_exp_len: assert property (p_exp_len)
    else $error("bad exposure length");

  property p_fs_after_exp;
    o_frame_start && i_triggered && !i_fast_mode && !i_pulse_width
      |-> $past(o_exposing) && !o_exposing;
  endproperty
  a_fs_after_exp: assert property (p_fs_after_exp)
    else $error("readout before exposure end");

  property p_sw_lat;
    i_sw_trig && i_trig_src == tes_pkg::TES_SRC_SW && i_triggered
      && !i_fast_mode && !o_exposing && !o_readout && !o_frame_start
      && since_q > i_trigger_holdoff + 24'h4 |-> ##[3:4] o_trig_accepted;
  endproperty
  a_sw_lat: assert property (p_sw_lat)
    else $error("software trigger lost");

  property p_free;
    !$past(i_triggered) |-> !o_trig_accepted;
  endproperty
  a_free: assert property (p_free)
    else $error("trigger accepted in free run");

  property p_holdoff;
    o_trig_accepted && i_trigger_holdoff > 24'h3 |=> !o_trig_accepted [*3];
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("accept in holdoff");

  property p_out1;
    $past(i_nrst) && i_out1_sel == 4'h0 && $past(i_out1_sel) == 4'h0
      |-> o_out1 == $past(i_out1_low);
  endproperty
  a_out1: assert property (p_out1)
    else $error("output one polarity wrong");

  property p_limit;
    $rose(o_exp_limit) |-> o_exp_cur == i_exp_max || o_exp_cur == i_exp_min;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit flag off limit");

  property p_fast_drop;
    o_frame_start && i_triggered && i_fast_mode && !i_pulse_width
      && i_readout_time > 24'h7 |=> !o_frame_start [*6];
  endproperty
  a_fast_drop: assert property (p_fast_drop)
    else $error("fast readout restarted early");
endmodule

bind tes_top tes_top_chk #(.EXP_W(EXP_W), .CNT_W(CNT_W)) u_tes_top_chk (
  .i_sys_clk, .i_nrst, .i_triggered, .i_fast_mode, .i_pulse_width,
  .i_trig_src, .i_trigger_holdoff, .i_exp_time, .i_readout_time,
  .i_sw_trig, .i_ae_en, .i_exp_min, .i_exp_max, .i_out1_sel, .i_out1_low,
  .o_out1, .o_exposing, .o_readout, .o_frame_start, .o_trig_accepted,
  .o_exp_cur, .o_exp_limit
);

// ### testbench/tes_top_test.sv
// self-checking bench of the trigger and exposure sequencer
`timescale 1ns/1ps

module tes_top_test;
  logic        i_sys_clk = 1'b0, i_nrst = 1'b0, i_triggered = 1'b1;
  logic        i_fast_mode = 1'b0, i_pulse_width = 1'b0, i_edge_falling = 1'b0;
  logic        i_overlap_accept = 1'b0, i_sw_trig = 1'b0, i_pulse_gen = 1'b0;
  logic        i_ae_en = 1'b0, i_ag_en = 1'b0, i_use_peak = 1'b0;
  logic        i_slaved_window_metering = 1'b0, i_pix_valid = 1'b0;
  logic        i_pix_in_window = 1'b0, i_frame_end = 1'b0, fire = 1'b0;
  logic        i_out1_low = 1'b1, i_out2_low = 1'b0, i_ce = 1'b1;
  logic [1:0]  i_ae_speed = 2'h0;
  logic [2:0]  i_trig_src = 3'h3;
  logic [3:0]  i_out1_sel = 4'h0, i_out2_sel = 4'h1;
  logic [7:0]  width = 8'h00;
  logic [11:0] i_lum_target = 12'h800, i_pix_data = 12'h000;
  logic [11:0] i_gain_min = 12'h000, i_gain_max = 12'h100;
  logic [23:0] i_frames_per_trig = 24'h1, i_glitch_min = 24'h4;
  logic [23:0] i_trigger_holdoff = 24'h8, i_readout_time = 24'ha;
  logic [29:0] i_exp_time = 30'h6, i_exp_min = 30'h64, i_exp_max = 30'h1770;
  wire         i_trigger_input_one, i_trigger_input_two, i_cc1;
  logic        o_out1, o_out2, o_exposing, o_readout, o_frame_start;
  logic        o_trig_accepted, o_exp_limit, o_gain_limit;
  logic [11:0] o_lum, o_gain_cur;
  logic [29:0] o_exp_cur;
  logic [2:0]  srcs [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  int          num_errors, checked, n_acc, n_fs, n_exp;
  int          n_o2, run, last_len, a0, f0, e0, o0;

  tes_top u_tes_top (
    .i_sys_clk, .i_nrst, .i_ce, .i_triggered, .i_fast_mode,
    .i_pulse_width, .i_edge_falling, .i_overlap_accept, .i_trig_src,
    .i_frames_per_trig, .i_glitch_min, .i_trigger_holdoff, .i_exp_time,
    .i_readout_time, .i_trigger_input_one, .i_trigger_input_two, .i_cc1,
    .i_pulse_gen, .i_sw_trig, .i_ae_en, .i_ag_en, .i_lum_target, .i_use_peak,
    .i_slaved_window_metering, .i_ae_speed, .i_exp_min, .i_exp_max,
    .i_gain_min, .i_gain_max, .i_pix_valid, .i_pix_data, .i_pix_in_window,
    .i_frame_end, .i_out1_sel, .i_out1_low, .i_out2_sel, .i_out2_low,
    .o_out1, .o_out2, .o_exposing, .o_readout, .o_frame_start,
    .o_trig_accepted, .o_lum, .o_exp_cur, .o_gain_cur, .o_exp_limit,
    .o_gain_limit
  );

  tes_trig_model u_tes_trig_model (
    .i_sys_clk, .i_nrst, .i_fire(fire), .i_width(width), .i_sel(i_trig_src),
    .i_low(i_edge_falling), .o_in1(i_trigger_input_one),
    .o_in2(i_trigger_input_two), .o_cc1(i_cc1)
  );

  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // event counters
  always @(posedge i_sys_clk) begin
    n_acc += (o_trig_accepted === 1'b1);
    n_fs  += (o_frame_start === 1'b1);
    n_o2  += (o_out2 === 1'b1);
    if (o_exposing === 1'b1) begin
      n_exp++;
      run++;
    end else if (run != 0) begin
      last_len = run;
      run      = 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic snap;
    a0 = n_acc;
    f0 = n_fs;
    e0 = n_exp;
    o0 = n_o2;
  endtask

  task automatic sw;
    @(posedge i_sys_clk);
    i_sw_trig <= 1'b1;
    @(posedge i_sys_clk);
    i_sw_trig <= 1'b0;
  endtask

  task automatic pin(input logic [7:0] w);
    @(posedge i_sys_clk);
    fire  <= 1'b1;
    width <= w;
    @(posedge i_sys_clk);
    fire <= 1'b0;
    tick(w + 60);
  endtask

  // 16 pixels; odd ones inside the window
  task automatic frame(input logic [11:0] a, input logic [11:0] b);
    for (int k = 0; k < 16; k++) begin
      @(posedge i_sys_clk);
      i_pix_valid     <= 1'b1;
      i_pix_data      <= k[0] ? b : a;
      i_pix_in_window <= k[0];
    end
    @(posedge i_sys_clk);
    i_pix_valid <= 1'b0;
    i_frame_end <= 1'b1;
    @(posedge i_sys_clk);
    i_frame_end <= 1'b0;
    tick(4);
  endtask

  task automatic give_verdict;
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    tick(10000);
    num_errors++;
    give_verdict();
  end

  initial begin
    tick(20);
    i_nrst <= 1'b1;
    tick(3);
    check(o_exp_cur, 32'h1388);
    check(o_gain_cur, 32'h0);
    i_frames_per_trig <= 24'h2;
    tick(20);
    snap();
    sw();
    tick(80);
    check(n_acc - a0, 1);
    check(n_fs - f0, 2);
    check(n_exp - e0, 12);
    check(n_o2 - o0, 12);
    i_frames_per_trig <= 24'h1;
    i_readout_time    <= 24'h64;
    i_trigger_holdoff <= 24'h14;
    i_overlap_accept  <= 1'b1;
    tick(2);
    snap();
    sw();
    tick(5);
    sw();
    tick(30);
    sw();
    tick(150);
    check(n_acc - a0, 2);
    check(n_fs - f0, 2);
    i_overlap_accept <= 1'b0;
    snap();
    sw();
    tick(30);
    sw();
    tick(150);
    check(n_fs - f0, 1);
    i_readout_time <= 24'ha;
    for (int s = 0; s < 4; s++) begin
      i_trig_src     <= srcs[s];
      i_edge_falling <= (srcs[s] == 3'h1);
      tick(10);
      snap();
      if (srcs[s] == 3'h2) begin
        i_pulse_gen <= 1'b1;
        tick(20);
        i_pulse_gen <= 1'b0;
        tick(60);
      end else begin
        if (srcs[s] != 3'h4)
          pin(8'h02);
        pin(8'h14);
      end
      check(n_acc - a0, 1);
      check(n_fs - f0, 1);
    end
    i_trig_src    <= 3'h0;
    i_pulse_width <= 1'b1;
    tick(10);
    snap();
    pin(8'h28);
    check(last_len inside {[30:44]}, 1);
    check(n_fs - f0, 1);
    i_pulse_width <= 1'b0;
    i_triggered   <= 1'b0;
    i_trig_src    <= 3'h3;
    tick(5);
    snap();
    sw();
    tick(100);
    check(n_acc - a0, 0);
    check(n_fs - f0 > 5, 1);
    i_triggered       <= 1'b1;
    i_fast_mode       <= 1'b1;
    i_readout_time    <= 24'h1e;
    i_exp_time        <= 30'ha;
    i_trigger_holdoff <= 24'h2;
    tick(60);
    snap();
    sw();
    tick(10);
    sw();
    tick(40);
    sw();
    tick(50);
    check(n_fs - f0, 2);
    check(n_exp - e0, 20);
    i_fast_mode <= 1'b0;
    i_ae_en     <= 1'b1;
    i_ag_en     <= 1'b1;
    tick(40);
    frame(12'h100, 12'h100);
    check(o_lum, 32'h100);
    check(o_exp_cur, 32'h1770);
    check(o_exp_limit, 32'h1);
    i_slaved_window_metering <= 1'b1;
    frame(12'h000, 12'h400);
    check(o_lum, 32'h400);
    check(o_gain_cur, 32'h100);
    check(o_gain_limit, 32'h1);
    i_ce <= 1'b0;
    frame(12'h100, 12'h300);
    check(o_lum, 32'h400);
    i_ce <= 1'b1;
    i_slaved_window_metering <= 1'b0;
    i_use_peak               <= 1'b1;
    i_ae_speed               <= 2'h3;
    frame(12'h100, 12'h300);
    check(o_lum, 32'h300);
    give_verdict();
  end
endmodule
